// File: hdl/dtp_pkg.sv
// Shared constants, register map and field layouts of the dual timer block
package dtp_pkg;
    localparam int AW = 6;
    localparam logic [AW-1:0] OFF_T0_CNT = 6'h00;
    localparam logic [AW-1:0] OFF_T0_MODE = 6'h04;
    localparam logic [AW-1:0] OFF_PCON_B = 6'h08;
    localparam logic [AW-1:0] OFF_T1_CNT = 6'h0C;
    localparam logic [AW-1:0] OFF_T1_CTLA = 6'h10;
    localparam logic [AW-1:0] OFF_T1_CTLB = 6'h14;
    localparam logic [AW-1:0] OFF_PS1_VAL = 6'h18;
    localparam logic [AW-1:0] OFF_PWM_DUTY = 6'h1C;
    localparam logic [AW-1:0] OFF_BZ_CTL = 6'h20;
    localparam logic [AW-1:0] OFF_IRQ_FLAG = 6'h24;
    localparam logic [AW-1:0] OFF_IRQ_EN = 6'h28;
    localparam logic [AW-1:0] OFF_PIN_CFG = 6'h2C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int PCON_RUN = 0;
    localparam int PCON_GIE = 7;
    localparam int FLAG_T0 = 0;
    localparam int FLAG_T1 = 3;
    localparam logic [7:0] IRQ_MASK = 8'h09;
    localparam int CFG_BUZZER = 0;
    localparam int CFG_ASYNC = 1;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] T0_MODE_RST = 8'h08;
    localparam logic [7:0] T1_CTLB_RST = 8'h08;
    typedef struct packed {
        logic slow_sel;
        logic rsvd6;
        logic source_sel;
        logic edge_sel;
        logic prescaler_assign;
        logic [2:0] ratio;
    } dtp_t0_mode_t;
    typedef struct packed {
        logic pwm_output_enable;
        logic pwm_polarity_sel;
        logic [2:0] rsvd;
        logic one_shot;
        logic reload_sel;
        logic run;
    } dtp_t1_ctla_t;
    typedef struct packed {
        logic [1:0] rsvd;
        logic source_sel;
        logic edge_sel;
        logic prescaler_enable_n;
        logic [2:0] ratio;
    } dtp_t1_ctlb_t;
endpackage

// File: hdl/dtp_edge_det.sv
// Count-clock edge detector with optional synchroniser bypass
`timescale 1ns/1ns
module dtp_edge_det (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sig_i,
    input wire logic falling_i,
    input wire logic sync_i,
    output logic pulse_o
);
    logic s1_r;
    logic s2_r;
    logic s2d_r;
    logic raw_d_r;
    logic edge_s;
    logic edge_a;
    // Two-flop synchroniser, history of both paths
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s2d_r <= 1'b0;
            raw_d_r <= 1'b0;
        end else begin
            s1_r <= sig_i;
            s2_r <= s1_r;
            s2d_r <= s2_r;
            raw_d_r <= sig_i;
        end
    end
    // Falling or rising edge per select
    assign edge_s = falling_i ? (s2d_r & ~s2_r) : (s2_r & ~s2d_r);
    assign edge_a = falling_i ? (raw_d_r & ~sig_i) : (sig_i & ~raw_d_r);
    assign pulse_o = sync_i ? edge_s : edge_a;
endmodule // dtp_edge_det

// File: hdl/dtp_prescaler.sv
// Binary prescaler with ratio select, clear and bypass
`timescale 1ns/1ns
module dtp_prescaler #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic tick_i,
    input wire logic bypass_i,
    input wire logic [2:0] ratio_i,
    output logic tick_o,
    output logic [W-1:0] value_o
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] mask;
    logic term;
    // Running count, cleared on request
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (clr_i) begin
            cnt_r <= '0;
        end else if (tick_i) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
    // Terminal when low ratio+1 bits all set
    assign mask = W'((9'h002 << ratio_i) - 9'h001);
    assign term = ((cnt_r | ~mask) == {W{1'b1}});
    assign tick_o = bypass_i ? tick_i : (tick_i & term);
    assign value_o = cnt_r;
endmodule // dtp_prescaler

// File: hdl/dtp_top.sv
// Dual timer with PWM and buzzer output behind an AXI4-Lite slave
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
module dtp_top import dtp_pkg::*; #(
    parameter int CW = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic external_count_clock_i,
    input wire logic slow_internal_oscillator_i,
    output logic irq_o,
    output logic shared_output_pin_o,
    output logic shared_output_pin_oe_o
);
    // Bus channel state
    logic awready_r;
    logic wready_r;
    logic aw_full_r;
    logic w_full_r;
    logic [AW-1:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_do;
    // Software-visible registers
    logic [CW-1:0] t0_cnt_r;
    dtp_t0_mode_t t0_mode_r;
    logic [7:0] pcon_r;
    logic [CW-1:0] t1_cnt_r;
    logic [CW-1:0] t1_reload_r;
    dtp_t1_ctla_t t1a_r;
    dtp_t1_ctlb_t t1b_r;
    logic [CW-1:0] duty_r;
    logic bz_en_r;
    logic [3:0] bz_sel_r;
    logic [7:0] flags_r;
    logic [7:0] irq_enable_reg_r;
    logic [1:0] pin_cfg_r;
    // Internal timing nets
    logic ps0_clr_r;
    logic edge0;
    logic edge1;
    logic t0_src_tick;
    logic t0_tick;
    logic t1_src_tick;
    logic t1_tick;
    logic [CW-1:0] ps0_val;
    logic [CW-1:0] ps1_val;
    logic t0_ovf;
    logic t1_unf;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic pwm_level;
    logic bz_wave;
    logic irq_r;
    logic pin_r;
    logic pin_oe_r;

    // Write strobe for one register offset
    function automatic logic wr_at(input logic [AW-1:0] off);
        return wr_do && w_strb_r && (aw_addr_r == off);
    endfunction

    // Offset is a mapped register
    function automatic logic addr_ok(input logic [AW-1:0] a);
        return (a <= OFF_PIN_CFG) && (a[1:0] == 2'h0);
    endfunction

    assign wr_do = aw_full_r && w_full_r && !bvalid_r;

    // Write address channel, holds one address
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            awready_r <= 1'b1;
            aw_full_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid_i && awready_r) begin
            awready_r <= 1'b0;
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr_i;
        end else if (wr_do) begin
            awready_r <= 1'b1;
            aw_full_r <= 1'b0;
        end
    end

    // Write data channel, only the low byte lane matters
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wready_r <= 1'b1;
            w_full_r <= 1'b0;
            w_data_r <= RST_BYTE;
            w_strb_r <= 1'b0;
        end else if (s_axi_wvalid_i && wready_r) begin
            wready_r <= 1'b0;
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata_i[7:0];
            w_strb_r <= s_axi_wstrb_i[0];
        end else if (wr_do) begin
            wready_r <= 1'b1;
            w_full_r <= 1'b0;
        end
    end

    // Write response one cycle after both halves arrive
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid_r <= 1'b1;
            bresp_r <= addr_ok(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready_i) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read channel, data one cycle after address
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid_i && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= addr_ok(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= '0;
            if (s_axi_araddr_i == OFF_T0_CNT) begin
                rdata_r[CW-1:0] <= t0_cnt_r;
            end else if (s_axi_araddr_i == OFF_T0_MODE) begin
                rdata_r[7:0] <= t0_mode_r;
            end else if (s_axi_araddr_i == OFF_PCON_B) begin
                rdata_r[7:0] <= pcon_r;
            end else if (s_axi_araddr_i == OFF_T1_CNT) begin
                rdata_r[CW-1:0] <= t1_cnt_r;
            end else if (s_axi_araddr_i == OFF_T1_CTLA) begin
                rdata_r[7:0] <= t1a_r;
            end else if (s_axi_araddr_i == OFF_T1_CTLB) begin
                rdata_r[7:0] <= t1b_r;
            end else if (s_axi_araddr_i == OFF_PS1_VAL) begin
                rdata_r[CW-1:0] <= ps1_val;
            end else if (s_axi_araddr_i == OFF_PWM_DUTY) begin
                rdata_r[CW-1:0] <= duty_r;
            end else if (s_axi_araddr_i == OFF_BZ_CTL) begin
                rdata_r[7:0] <= {bz_en_r, 3'h0, bz_sel_r};
            end else if (s_axi_araddr_i == OFF_IRQ_FLAG) begin
                rdata_r[7:0] <= flags_r;
            end else if (s_axi_araddr_i == OFF_IRQ_EN) begin
                rdata_r[7:0] <= irq_enable_reg_r;
            end else if (s_axi_araddr_i == OFF_PIN_CFG) begin
                rdata_r[1:0] <= pin_cfg_r;
            end
        end else if (rvalid_r && s_axi_rready_i) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
        end
    end

    // Plain control registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            t0_mode_r <= T0_MODE_RST;
            pcon_r <= RST_BYTE;
            t1b_r <= T1_CTLB_RST;
            duty_r <= '0;
            bz_en_r <= 1'b0;
            bz_sel_r <= 4'h0;
            irq_enable_reg_r <= RST_BYTE;
            pin_cfg_r <= 2'h0;
        end else begin
            if (wr_at(OFF_T0_MODE)) t0_mode_r <= w_data_r;
            if (wr_at(OFF_PCON_B)) pcon_r <= w_data_r;
            if (wr_at(OFF_T1_CTLB)) t1b_r <= w_data_r;
            if (wr_at(OFF_PWM_DUTY)) duty_r <= w_data_r[CW-1:0];
            if (wr_at(OFF_BZ_CTL)) bz_en_r <= w_data_r[7];
            if (wr_at(OFF_BZ_CTL)) bz_sel_r <= w_data_r[3:0];
            if (wr_at(OFF_IRQ_EN)) irq_enable_reg_r <= w_data_r & IRQ_MASK;
            if (wr_at(OFF_PIN_CFG)) pin_cfg_r <= w_data_r[1:0];
        end
    end

    // Prescaler clear after a zero written to the assign bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ps0_clr_r <= 1'b0;
        end else begin
            ps0_clr_r <= wr_at(OFF_T0_MODE) && !w_data_r[3];
        end
    end

    // First counter source edge, pin or slow oscillator
    dtp_edge_det u_edge0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(t0_mode_r.slow_sel ? slow_internal_oscillator_i
                                  : external_count_clock_i),
        .falling_i(t0_mode_r.edge_sel),
        .sync_i(!pin_cfg_r[CFG_ASYNC]),
        .pulse_o(edge0)
    );

    // Instruction clock or selected edge, gated by run bit
    assign t0_src_tick = t0_mode_r.source_sel ? edge0 : 1'b1;

    // First prescaler, bypassed when assigned away
    dtp_prescaler #(.W(CW)) u_ps0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(ps0_clr_r),
        .tick_i(pcon_r[PCON_RUN] && t0_src_tick),
        .bypass_i(t0_mode_r.prescaler_assign),
        .ratio_i(t0_mode_r.ratio),
        .tick_o(t0_tick),
        .value_o(ps0_val)
    );

    // First counter counts up; a write wins over a tick
    assign t0_ovf = t0_tick && (t0_cnt_r == CNT_MAX) && !wr_at(OFF_T0_CNT);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            t0_cnt_r <= '0;
        end else if (wr_at(OFF_T0_CNT)) begin
            t0_cnt_r <= w_data_r[CW-1:0];
        end else if (t0_tick) begin
            t0_cnt_r <= t0_cnt_r + 1'b1;
        end
    end

    // Second counter source edge, always synchronised
    dtp_edge_det u_edge1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(external_count_clock_i),
        .falling_i(t1b_r.edge_sel),
        .sync_i(1'b1),
        .pulse_o(edge1)
    );

    assign t1_src_tick = t1b_r.source_sel ? edge1 : 1'b1;

    // Second prescaler, active when its enable is low
    dtp_prescaler #(.W(CW)) u_ps1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(1'b0),
        .tick_i(t1a_r.run && t1_src_tick),
        .bypass_i(t1b_r.prescaler_enable_n),
        .ratio_i(t1b_r.ratio),
        .tick_o(t1_tick),
        .value_o(ps1_val)
    );

    // Underflow is a tick seen at zero
    assign t1_unf = t1_tick && (t1_cnt_r == CNT_ZERO) && !wr_at(OFF_T1_CNT);

    // Second counter and its reload register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            t1_cnt_r <= '0;
            t1_reload_r <= '0;
        end else if (wr_at(OFF_T1_CNT)) begin
            t1_cnt_r <= w_data_r[CW-1:0];
            t1_reload_r <= w_data_r[CW-1:0];
        end else if (t1_unf) begin
            if (t1a_r.one_shot) begin
                t1_cnt_r <= '0;
            end else if (t1a_r.reload_sel) begin
                t1_cnt_r <= t1_reload_r;
            end else begin
                t1_cnt_r <= CNT_MAX;
            end
        end else if (t1_tick) begin
            t1_cnt_r <= t1_cnt_r - 1'b1;
        end
    end

    // Control A; one-shot underflow drops the run bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            t1a_r <= RST_BYTE;
        end else if (wr_at(OFF_T1_CTLA)) begin
            t1a_r <= w_data_r;
        end else if (t1_unf && t1a_r.one_shot) begin
            t1a_r.run <= 1'b0;
        end
    end

    // Sticky flags: hardware set beats a software clear
    assign flag_set = {4'h0, t1_unf, 2'h0, t0_ovf};
    assign flag_clr = wr_at(OFF_IRQ_FLAG) ? ~w_data_r : RST_BYTE;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_r <= RST_BYTE;
        end else begin
            flags_r <= ((flags_r & ~flag_clr) | flag_set) & IRQ_MASK;
        end
    end

    // Interrupt request gated by enables and global enable
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= pcon_r[PCON_GIE] && |(flags_r & irq_enable_reg_r);
        end
    end

    // PWM active below duty, polarity applied last
    assign pwm_level = (t1_cnt_r < duty_r) ^ t1a_r.pwm_polarity_sel;

    // Buzzer taps a prescaler or counter bit
    assign bz_wave = bz_sel_r[3] ? t1_cnt_r[bz_sel_r[2:0]]
                                 : ps1_val[bz_sel_r[2:0]];

    // Shared pin driver and forced direction
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else if (pin_cfg_r[CFG_BUZZER]) begin
            pin_r <= bz_en_r && bz_wave;
            pin_oe_r <= bz_en_r;
        end else begin
            pin_r <= t1a_r.pwm_output_enable && pwm_level;
            pin_oe_r <= t1a_r.pwm_output_enable;
        end
    end

    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o = wready_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rdata_o = rdata_r;
    assign s_axi_rresp_o = rresp_r;
    assign irq_o = irq_r;
    assign shared_output_pin_o = pin_r;
    assign shared_output_pin_oe_o = pin_oe_r;
endmodule // dtp_top

// File: verification/dtp_checker.sv
// Bus checks, with irq and pin covers, on the dual timer top ports
`timescale 1ns/1ns
module dtp_checker import dtp_pkg::*; #(
    parameter int CW = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic irq_o,
    input wire logic shared_output_pin_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Write channel: take, answer two edges later, hold until taken
    a_write_lat: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o |=> ##1 s_axi_bvalid_o) else $error("write answer late");
    a_aw_drop: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
        else $error("awready stayed high");
    a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
        && $stable(s_axi_bresp_o)) else $error("write answer dropped");
    a_bvalid_clear: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("bvalid not cleared");
    // Read channel: one cycle answer, byte wide data, refused reads carry zero
    a_read_lat: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("read answer late");
    a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
        && $stable(s_axi_rdata_o)) else $error("read data dropped");
    a_rdata_byte: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
        else $error("read data above byte");
    a_slverr_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR
        |-> s_axi_rdata_o == 32'h0) else $error("refused read with data");
    // Main scenarios
    c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
    c_irq: cover property ($rose(irq_o));
    c_pin: cover property ($rose(shared_output_pin_oe_o));
endmodule // dtp_checker
bind dtp_top dtp_checker #(.CW(CW)) dtp_checker_inst (.*);

// File: verification/dtp_pin_model.sv
// Far side model: count clock sources and a meter on the shared pin
`timescale 1ns/1ns
module dtp_pin_model (
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic pin_oe_i,
    output logic ext_clk_o,
    output logic slow_osc_o,
    output logic meas_done_o,
    output logic [15:0] meas_val_o
);
    // Idle levels
    initial begin
        ext_clk_o = 1'b0;
        slow_osc_o = 1'b0;
        meas_done_o = 1'b0;
        meas_val_o = 16'h0;
    end
    // Four clocks per level keep edges slower than the sync path
    task automatic toggle(input bit slow, input int n);
        repeat (n) begin
            @(posedge clk_i);
            if (slow) slow_osc_o <= !slow_osc_o;
            else ext_clk_o <= !ext_clk_o;
            repeat (3) @(posedge clk_i);
        end
        repeat (8) @(posedge clk_i);
    endtask
    // Count pin changes, or cycles driven at the active level, over n clocks
    task automatic measure(input bit tgl, input bit act, input int n);
        logic prev;
        int cnt;
        cnt = 0;
        @(posedge clk_i);
        prev = pin_i;
        repeat (n) begin
            @(posedge clk_i);
            if (tgl ? pin_i !== prev : (pin_i === act && pin_oe_i === 1'b1)) cnt++;
            prev = pin_i;
        end
        meas_val_o <= 16'(cnt);
        meas_done_o <= 1'b1;
        @(posedge clk_i);
        meas_done_o <= 1'b0;
    endtask
endmodule // dtp_pin_model

// File: verification/dual_timer_pwm_buzzer_bench.sv
// Self-checking bench for the dual timer with PWM and buzzer
`timescale 1ns/1ns
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin err_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (x)); end end
module dual_timer_pwm_buzzer_bench import dtp_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [AW-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    wire logic awready, wready, bvalid, arready, rvalid, irq, pin, oe, ext_clk, slow_osc, mdone;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [15:0] mval;
    int err_count = 0, n_compared = 0;
    logic [1:0] bq[$], eb;
    logic [33:0] rq[$], er;
    logic [15:0] pq[$], ep;
    always #2 clk_i = ~clk_i;
    dtp_top dtp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .external_count_clock_i(ext_clk),
        .slow_internal_oscillator_i(slow_osc), .irq_o(irq), .shared_output_pin_o(pin),
        .shared_output_pin_oe_o(oe));
    dtp_pin_model dtp_pin_model_inst (.clk_i(clk_i), .pin_i(pin), .pin_oe_i(oe),
        .ext_clk_o(ext_clk), .slow_osc_o(slow_osc), .meas_done_o(mdone), .meas_val_o(mval));
    // Verdict and end of run
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Bus write; address and data released each when taken
    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d,
        input logic [1:0] r = RESP_OKAY, input logic [3:0] s = 4'h1);
        int i;
        bq.push_back(r);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b0;
        for (i = 0; i < 64; i++) begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        if (i == 64) err_count++;
    endtask
    // Bus read; expected data and response noted first
    task automatic rd(input logic [AW-1:0] a, input logic [7:0] d,
        input logic [1:0] r = RESP_OKAY);
        int i;
        rq.push_back({r, 24'h0, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b0;
        for (i = 0; i < 64; i++) begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        if (i == 64) err_count++;
    endtask
    // Result watcher: oldest note against each answer
    always @(posedge clk_i) begin
        if (bvalid && bready) begin
            eb = bq.pop_front();
            `CHK(bresp, eb)
        end
        if (rvalid && rready) begin
            er = rq.pop_front();
            `CHK({rresp, rdata}, er)
        end
        if (mdone) begin
            ep = pq.pop_front();
            `CHK(mval, ep)
        end
    end
    // Hang guard
    initial begin
        #200000;
        err_count++;
        test_done();
    end
    // Main sequence
    initial begin
        int i, n, m, t;
        logic sl, fe, ps, rl, lvl;
        logic [7:0] v, d, e;
        void'($urandom(32'h1b338dd3));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, then refused places
        for (i = 0; i < 12; i++) rd(AW'(4 * i), (i == 1 || i == 5) ? 8'h08 : 8'h00);
        rd(6'h30, 8'h00, RESP_SLVERR);
        rd(6'h01, 8'h00, RESP_SLVERR);
        wr(6'h3C, 8'h55, RESP_SLVERR);
        // Counter loads; a strobe-less write is dropped
        v = 8'($urandom);
        wr(OFF_T0_CNT, v);
        wr(OFF_T0_CNT, ~v, RESP_OKAY, 4'h0);
        rd(OFF_T0_CNT, v);
        wr(OFF_T1_CNT, ~v);
        rd(OFF_T1_CNT, ~v);
        // First counter from pin or slow source, either edge, prescaled or not
        for (i = 0; i < 8; i++) begin
            sl = i[0];
            fe = i[1];
            ps = i[2];
            n = 13 + 2 * i;
            wr(OFF_PIN_CFG, {6'h0, fe, 1'b0});
            wr(OFF_T0_MODE, {sl, 2'b01, fe, !ps, 3'h1});
            wr(OFF_T0_CNT, 8'h00);
            wr(OFF_PCON_B, 8'h01);
            dtp_pin_model_inst.toggle(sl, n);
            wr(OFF_PCON_B, 8'h00);
            dtp_pin_model_inst.toggle(sl, 1);
            m = fe ? n / 2 : (n + 1) / 2;
            rd(OFF_T0_CNT, 8'(ps ? m / 4 : m));
        end
        // Overflow flag, interrupt gating and clearing
        wr(OFF_T0_MODE, T0_MODE_RST);
        wr(OFF_T0_CNT, CNT_MAX);
        wr(OFF_IRQ_EN, 8'h01);
        wr(OFF_PCON_B, 8'h81);
        wr(OFF_PCON_B, 8'h80);
        wr(OFF_IRQ_FLAG, 8'hFF);
        rd(OFF_IRQ_FLAG, 8'h01);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_EN, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_EN, 8'h09);
        wr(OFF_IRQ_FLAG, 8'h00);
        rd(OFF_IRQ_FLAG, 8'h00);
        // One-shot run down to zero, then stop with the underflow flag
        wr(OFF_T1_CNT, 8'h05);
        wr(OFF_T1_CTLA, 8'h05);
        repeat (20) @(posedge clk_i);
        rd(OFF_T1_CNT, CNT_ZERO);
        rd(OFF_T1_CTLA, 8'h04);
        rd(OFF_IRQ_FLAG, 8'h08);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_FLAG, 8'h00);
        // Continuous runs from the pin: reload or 0xFF restart, either edge
        lvl = 1'b0;
        for (i = 0; i < 4; i++) begin
            fe = i[0];
            rl = i[1];
            ps = fe ^ rl;
            n = ps ? 7 : 9;
            wr(OFF_T1_CTLB, {3'b001, fe, !ps, 3'h0});
            wr(OFF_T1_CNT, 8'h01);
            wr(OFF_T1_CTLA, {6'h0, rl, 1'b1});
            dtp_pin_model_inst.toggle(1'b0, n);
            wr(OFF_T1_CTLA, 8'h00);
            m = (lvl == fe) ? (n + 1) / 2 : n / 2;
            lvl = !lvl;
            t = ps ? m / 2 : m;
            e = 8'h01;
            repeat (t) e = (e == 8'h00) ? (rl ? 8'h01 : CNT_MAX) : e - 8'h01;
            rd(OFF_T1_CNT, e);
        end
        // PWM frames of ten clocks, duty clocks active each
        wr(OFF_T1_CTLB, T1_CTLB_RST);
        wr(OFF_PIN_CFG, 8'h00);
        wr(OFF_T1_CNT, 8'h09);
        for (i = 0; i < 4; i++) begin
            d = 8'($urandom_range(9));
            wr(OFF_PWM_DUTY, d);
            wr(OFF_T1_CTLA, {1'b1, i[0], 6'h03});
            pq.push_back(16'(4 * d));
            dtp_pin_model_inst.measure(1'b0, !i[0], 40);
            `CHK(oe, 1'b1)
        end
        // Buzzer taps: prescaler bits, then counter bits
        wr(OFF_PIN_CFG, 8'h01);
        wr(OFF_T1_CTLA, 8'h01);
        for (i = 0; i < 16; i++) begin
            wr(OFF_T1_CTLB, i[3] ? T1_CTLB_RST : 8'h07);
            wr(OFF_BZ_CTL, {4'h8, 4'(i)});
            pq.push_back(16'(256 >> i[2:0]));
            dtp_pin_model_inst.measure(1'b1, 1'b0, 256);
        end
        `CHK(oe, 1'b1)
        repeat (4) @(posedge clk_i);
        test_done();
    end
endmodule // dual_timer_pwm_buzzer_bench
